// [link_error_lock_monitor.sv]
// forward link error counter, lock decision and debug register file
// assumes error flags and raw lock come from logic on clock_i
// Operation
// - count errors only while count enable set
// - drop lock when count reaches threshold
// - counter disabled, drop lock on first error
// - counter runs on pixel clock
// - parity, clock, control errors are link errors
// - each error source maskable by debug bits
// - optionally ignore errors in filter wait period
// - crc control bit low enables crc check
// - pulldown on unless output mode or disabled
// - report remote self-test, flag mismatch
// - continuous back-channel bit errors while set
// - one bit error into one frame
`timescale 1ns/1ps
`default_nettype none
module link_error_lock_monitor
  import lock_mon_pkg::*;
#(
  parameter int WAIT_CYCLES = lock_mon_pkg::FILTER_WAIT_CYCLES,
  parameter int NUM_GPIO = lock_mon_pkg::GPIO_COUNT
) (
  input wire logic clock_i, // pixel clock, 20 MHz
  input wire logic nrst_i, // synchronous reset, active low
  input wire lock_mon_pkg::reg_req_t req_i, // register strobes, address, data
  output logic [7:0] rdata_o, // read data, cycle after read strobe
  input wire lock_mon_pkg::link_err_t err_i, // per-cycle link error flags
  input wire logic rx_lock_raw_i, // lock circuit says locked
  input wire logic equalizer_filter_step_i, // filter control update pulse
  input wire logic remote_selftest_active_i, // decoded remote self-test flag
  input wire logic local_selftest_pin_i, // local self-test pin, async
  input wire logic frame_start_i, // outgoing back-channel frame start
  input wire logic [NUM_GPIO-1:0] gpio_output_mode_i, // pin driven as output
  output logic lock_o, // receiver lock
  output logic crc_check_en_o, // encoded packet crc check on
  output logic [NUM_GPIO-1:0] pulldown_en_o, // pulldown resistor on
  output logic selftest_mismatch_o, // remote in self-test, local not
  output logic return_bit_flip_o // corrupt one bit of this frame
);

  localparam logic [7:0] WAIT_LOAD = 8'(WAIT_CYCLES);
  default clocking cb @(posedge clock_i); endclocking // assertions sample here
  default disable iff (!nrst_i);

  // register state
  logic [3:0] error_lock_threshold_q;
  logic count_en_q;
  logic filter_wait_error_mask_q;
  logic [7:0] encoder_crc_control_q;
  logic [2:0] source_mask_q;
  logic [7:0] reserved_bd_q;
  logic [NUM_GPIO-1:0] pin_pulldown_off_q;
  logic [7:0] debug_q;

  // lock and counter state
  logic lock_q;
  logic lock_d;
  logic [3:0] err_cnt_q;
  logic [3:0] err_cnt_d;
  logic [7:0] wait_cnt_q;
  logic [7:0] wait_cnt_d;
  logic [7:0] rdata_d;
  logic local_selftest;
  logic inject_pending;
  logic inject_flip;

  // address decode
  logic hit_ctl;
  logic hit_crc;
  logic hit_mask;
  logic hit_bd;
  logic hit_pd;
  logic hit_dbg;
  assign hit_ctl = (req_i.addr == OFS_LINK_ERROR_CONTROL);
  assign hit_crc = (req_i.addr == OFS_ENCODER_CRC_CONTROL);
  assign hit_mask = (req_i.addr == OFS_ERROR_SOURCE_MASK);
  assign hit_bd = (req_i.addr == OFS_RESERVED_BD);
  assign hit_pd = (req_i.addr == OFS_GPIO_PULLDOWN_DISABLE);
  assign hit_dbg = (req_i.addr == OFS_DEBUG_INJECTION_STATUS);

  // write enables
  logic we_ctl;
  logic we_crc;
  logic we_mask;
  logic we_bd;
  logic we_pd;
  logic we_dbg;
  assign we_ctl = req_i.wr & hit_ctl;
  assign we_crc = req_i.wr & hit_crc;
  assign we_mask = req_i.wr & hit_mask;
  assign we_bd = req_i.wr & hit_bd;
  assign we_pd = req_i.wr & hit_pd;
  assign we_dbg = req_i.wr & hit_dbg;

  // one-shot request only on a written zero-to-one edge of the bit
  logic one_rise;
  assign one_rise = we_dbg & req_i.wdata[INJ_ONE_BIT] & ~debug_q[INJ_ONE_BIT];

  // read views; unused bits and unmapped addresses read zero; the reserved register reads back
  logic [7:0] view_ctl;
  logic [7:0] view_pd;
  logic [7:0] view_dbg;
  assign view_ctl = {2'h0, filter_wait_error_mask_q, count_en_q, error_lock_threshold_q};
  assign view_pd = {{(8 - NUM_GPIO){1'b0}}, pin_pulldown_off_q};
  // remote flag is live, never stored by a write
  assign view_dbg = {debug_q[7:6], remote_selftest_active_i, debug_q[4:0]};

  assign rdata_d = !req_i.rd ? 8'h00 :
                   hit_ctl ? view_ctl :
                   hit_crc ? encoder_crc_control_q :
                   hit_mask ? {5'h00, source_mask_q} :
                   hit_bd ? reserved_bd_q :
                   hit_pd ? view_pd :
                   hit_dbg ? view_dbg : 8'h00;

  // qualified error: each source gated by its own debug mask
  logic [2:0] err_vec;
  logic raw_err;
  logic wait_active;
  logic counted_err;
  assign err_vec = {err_i.parity, err_i.clock, err_i.control} & ~source_mask_q;
  assign raw_err = |err_vec;
  assign wait_active = (wait_cnt_q != 8'h00);
  // errors in the filter wait period only drop lock when the mask is off
  assign counted_err = raw_err & ~(wait_active & filter_wait_error_mask_q);

  // threshold compare on the count the error would produce
  logic [4:0] cnt_next;
  logic reach;
  assign cnt_next = {1'b0, err_cnt_q} + 5'h01;
  // a threshold of zero behaves as one: lock falls on the first error
  assign reach = (cnt_next >= {1'b0, error_lock_threshold_q});

  // next lock state and counter
  always_comb
  begin
    lock_d = lock_q;
    err_cnt_d = err_cnt_q;
    if (!rx_lock_raw_i)
    begin
      lock_d = 1'b0;
      err_cnt_d = 4'h0;
    end
    else if (!lock_q)
    begin
      lock_d = 1'b1;
      err_cnt_d = 4'h0;
    end
    else if (counted_err)
    begin
      if (!count_en_q)
      begin
        lock_d = 1'b0;
      end
      else if (reach)
      begin
        lock_d = 1'b0;
        err_cnt_d = 4'h0;
      end
      else
      begin
        err_cnt_d = cnt_next[3:0];
      end
    end
    if (!count_en_q)
    begin
      err_cnt_d = 4'h0;
    end
  end

  // filter wait window restarts on every filter step
  assign wait_cnt_d = equalizer_filter_step_i ? WAIT_LOAD :
                      wait_active ? wait_cnt_q - 8'h01 : 8'h00;

  // lock and counter flops on the pixel clock
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      lock_q <= 1'b0;
      err_cnt_q <= 4'h0;
      wait_cnt_q <= 8'h00;
    end
    else
    begin
      lock_q <= lock_d;
      err_cnt_q <= err_cnt_d;
      wait_cnt_q <= wait_cnt_d;
    end
  end

  // link error control, crc control and source mask registers
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      error_lock_threshold_q <= RST_THRESH;
      count_en_q <= RST_COUNT_EN;
      filter_wait_error_mask_q <= RST_WAIT_MASK;
      encoder_crc_control_q <= RST_ENCODER_CRC;
      source_mask_q <= RST_SOURCE_MASK;
    end
    else
    begin
      if (we_ctl)
      begin
        error_lock_threshold_q <= req_i.wdata[THRESH_LSB +: 4];
        count_en_q <= req_i.wdata[COUNT_EN_BIT];
        filter_wait_error_mask_q <= req_i.wdata[WAIT_MASK_BIT];
      end
      if (we_crc)
      begin
        encoder_crc_control_q <= req_i.wdata;
      end
      if (we_mask)
      begin
        source_mask_q <= req_i.wdata[2:0];
      end
    end
  end

  // spare, pulldown and debug registers
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      reserved_bd_q <= RST_RESERVED_BD;
      pin_pulldown_off_q <= RST_PULLDOWN_OFF[NUM_GPIO-1:0];
      debug_q <= RST_DEBUG;
    end
    else
    begin
      if (we_bd)
      begin
        reserved_bd_q <= req_i.wdata;
      end
      if (we_pd)
      begin
        pin_pulldown_off_q <= req_i.wdata[NUM_GPIO-1:0];
      end
      if (we_dbg)
      begin
        debug_q <= req_i.wdata;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= 8'h00;
      lock_o <= 1'b0;
      crc_check_en_o <= 1'b0;
      pulldown_en_o <= '0;
      selftest_mismatch_o <= 1'b0;
    end
    else
    begin
      rdata_o <= rdata_d;
      lock_o <= lock_d;
      crc_check_en_o <= ~encoder_crc_control_q[CRC_DIS_BIT];
      pulldown_en_o <= ~gpio_output_mode_i & ~pin_pulldown_off_q;
      selftest_mismatch_o <= remote_selftest_active_i & ~local_selftest;
    end
  end

  // local self-test state arrives on a pin
  pin_sync3 u_selftest_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .pin_i(local_selftest_pin_i),
    .level_o(local_selftest)
  );

  // back-channel error injection
  return_err_inject u_inject (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .frame_start_i(frame_start_i),
    .continuous_i(debug_q[INJ_CONT_BIT]),
    .one_rise_i(one_rise),
    .flip_o(inject_flip),
    .pending_o(inject_pending)
  );
  assign return_bit_flip_o = inject_flip;

  // checks

  property p_count_gate;
    !count_en_q |=> err_cnt_q == 4'h0;
  endproperty
  a_count_gate: assert property (p_count_gate)
    else $error("counter moved while disabled");

  property p_threshold_drop;
    lock_q && rx_lock_raw_i && count_en_q && counted_err && reach
      |=> !lock_o ##1 lock_o == $past(rx_lock_raw_i); // relock only if raw lock stays
  endproperty
  a_threshold_drop: assert property (p_threshold_drop)
    else $error("lock not dropped at threshold");

  property p_below_hold;
    lock_q && rx_lock_raw_i && count_en_q && counted_err && !reach
      |=> lock_o && err_cnt_q == $past(err_cnt_q) + 4'h1;
  endproperty
  a_below_hold: assert property (p_below_hold)
    else $error("lock lost below threshold");

  property p_first_error;
    lock_q && rx_lock_raw_i && !count_en_q && counted_err |=> !lock_q;
  endproperty
  a_first_error: assert property (p_first_error)
    else $error("disabled counter kept lock on error");

  property p_masked_sources;
    lock_q && rx_lock_raw_i && source_mask_q == 3'h7 |=> lock_q;
  endproperty
  a_masked_sources: assert property (p_masked_sources)
    else $error("masked error dropped lock");

  property p_wait_ignore;
    lock_q && rx_lock_raw_i && wait_active && filter_wait_error_mask_q |=> lock_q;
  endproperty
  a_wait_ignore: assert property (p_wait_ignore)
    else $error("error in wait period dropped lock");

  property p_crc_enable;
    we_crc |=> ##1 crc_check_en_o == !$past(req_i.wdata[CRC_DIS_BIT], 2);
  endproperty
  a_crc_enable: assert property (p_crc_enable)
    else $error("crc enable does not follow control bit");

  property p_pulldown;
    $past(nrst_i) |-> pulldown_en_o == $past(~gpio_output_mode_i & ~pin_pulldown_off_q);
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pulldown state wrong");

  property p_selftest_read;
    req_i.rd && hit_dbg |=> rdata_o[SELFTEST_BIT] == $past(remote_selftest_active_i);
  endproperty
  a_selftest_read: assert property (p_selftest_read)
    else $error("remote self-test flag misread");

  property p_continuous;
    debug_q[INJ_CONT_BIT] && frame_start_i |=> return_bit_flip_o;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous injection missed a frame");

  property p_one_shot;
    inject_pending && frame_start_i && !one_rise |=> return_bit_flip_o && !inject_pending;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot injection wrong");

  property p_acquire;
    !lock_q && rx_lock_raw_i |=> lock_q && err_cnt_q == 4'h0;
  endproperty
  a_acquire: assert property (p_acquire)
    else $error("counter not cleared on lock");

  c_threshold_drop: cover property (lock_q && count_en_q && counted_err && reach);
  c_wait_ignored: cover property (lock_q && raw_err && wait_active && filter_wait_error_mask_q);
  c_one_shot: cover property (one_rise ##[1:20] return_bit_flip_o);
  c_mismatch: cover property (selftest_mismatch_o);

endmodule : link_error_lock_monitor
`default_nettype wire

// [lock_mon_pkg.sv]
// constants, register map and carrier types of the link error lock monitor
// assumes an 8-bit register port and a single pixel clock
`default_nettype none
package lock_mon_pkg;

  // register offsets
  localparam logic [7:0] OFS_LINK_ERROR_CONTROL = 8'hb9;
  localparam logic [7:0] OFS_ENCODER_CRC_CONTROL = 8'hba;
  localparam logic [7:0] OFS_ERROR_SOURCE_MASK = 8'hbc;
  localparam logic [7:0] OFS_RESERVED_BD = 8'hbd;
  localparam logic [7:0] OFS_GPIO_PULLDOWN_DISABLE = 8'hbe;
  localparam logic [7:0] OFS_DEBUG_INJECTION_STATUS = 8'hd0;

  // field positions
  localparam int THRESH_LSB = 0;
  localparam int COUNT_EN_BIT = 4;
  localparam int WAIT_MASK_BIT = 5;
  localparam int CRC_DIS_BIT = 7;
  localparam int SELFTEST_BIT = 5;
  localparam int INJ_CONT_BIT = 1;
  localparam int INJ_ONE_BIT = 0;

  // values after reset
  localparam logic [3:0] RST_THRESH = 4'h3;
  localparam logic RST_COUNT_EN = 1'b1;
  localparam logic RST_WAIT_MASK = 1'b1;
  localparam logic [7:0] RST_ENCODER_CRC = 8'h83;
  localparam logic [7:0] RST_RESERVED_BD = 8'h00;
  localparam logic [6:0] RST_PULLDOWN_OFF = 7'h00;
  localparam logic [7:0] RST_DEBUG = 8'h00;
  localparam logic [2:0] RST_SOURCE_MASK = 3'h0;

  // cycles of the wait period after an equalizer filter step
  localparam int FILTER_WAIT_CYCLES = 16;

  localparam int GPIO_COUNT = 7;

  // one pixel-clock sample of the three link error sources
  typedef struct packed {
    logic parity;
    logic clock;
    logic control;
  } link_err_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : lock_mon_pkg
`default_nettype wire

// [pin_sync3.sv]
// three-flop synchroniser for an asynchronous pin level
// assumes the pin may change at any time relative to clock_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
  input wire logic clock_i, // pixel clock
  input wire logic nrst_i, // synchronous reset, active low
  input wire logic pin_i, // raw asynchronous level
  output logic level_o // filtered level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic agree;

  // a change is accepted once the second and third stages agree
  assign agree = (s2_q == s3_q);

  // chain; first stage feeds only the second
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree)
      begin
        level_o <= s3_q;
      end
    end
  end

endmodule : pin_sync3
`default_nettype wire

// [return_err_inject.sv]
// back-channel frame bit-error injector
// assumes frame_start_i is a one-cycle pulse per outgoing frame
`timescale 1ns/1ps
`default_nettype none
module return_err_inject (
  input wire logic clock_i, // pixel clock
  input wire logic nrst_i, // synchronous reset, active low
  input wire logic frame_start_i, // start of an outgoing frame
  input wire logic continuous_i, // corrupt every frame
  input wire logic one_rise_i, // request for one corrupt frame
  output logic flip_o, // flip one bit of this frame
  output logic pending_o // one-shot request still waiting
);

  logic fire_one;

  assign fire_one = pending_o & frame_start_i;

  // request arriving while an old one is spent still stands
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      pending_o <= 1'b0;
      flip_o <= 1'b0;
    end
    else
    begin
      if (one_rise_i)
      begin
        pending_o <= 1'b1;
      end
      else if (fire_one)
      begin
        pending_o <= 1'b0;
      end
      flip_o <= frame_start_i & (continuous_i | pending_o);
    end
  end

endmodule : return_err_inject
`default_nettype wire

// [ser_partner.sv]
// serializer-side model: back-channel frame timing and forward link error flags
// assumes the bench requests errors one cycle ahead on the same pixel clock
`timescale 1ns/1ps
`default_nettype none
module ser_partner
  import lock_mon_pkg::*;
#(
  parameter int FRAME_LEN = 8
) (
  input wire logic clock_i, // pixel clock
  input wire logic nrst_i, // synchronous reset, active low
  input wire lock_mon_pkg::link_err_t err_req_i, // errors to put on the link
  output lock_mon_pkg::link_err_t err_o, // errors seen by the deserializer
  output logic frame_start_o // one-cycle frame start pulse
);
  logic [7:0] frame_cnt_q;

  // fixed frame period so that flip counts per window are exact
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      frame_cnt_q <= 8'h00;
      err_o <= '0;
    end
    else
    begin
      frame_cnt_q <= (frame_cnt_q == 8'(FRAME_LEN - 1)) ? 8'h00 : frame_cnt_q + 8'h01;
      err_o <= err_req_i;
    end
  end

  // no frames while held in reset
  assign frame_start_o = (frame_cnt_q == 8'h00) && nrst_i;
endmodule : ser_partner
`default_nettype wire

// [tb_link_error_lock_monitor.sv]
// self-checking bench for the link error lock monitor
// assumes ser_partner plays the serializer; pixel clock 20 MHz
`timescale 1ns/1ps
`default_nettype none
module tb_link_error_lock_monitor;
  import lock_mon_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  reg_req_t req = '0;
  link_err_t err_req = '0;
  link_err_t err;
  logic raw = 1'b0;
  logic step = 1'b0;
  logic remote = 1'b0;
  logic local_pin = 1'b0;
  logic [6:0] gmode = 7'h00;
  logic [7:0] rdata;
  logic [6:0] pd_en;
  logic lock, crc_en, mism, flip, fstart;
  logic lock_d1 = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  int n_drop = 0;
  int n_flip = 0;

  ser_partner #(.FRAME_LEN(8)) partner (.clock_i(clock_i), .nrst_i(nrst_i),
    .err_req_i(err_req), .err_o(err), .frame_start_o(fstart));

  // short filter wait window keeps the run brief
  link_error_lock_monitor #(.WAIT_CYCLES(4), .NUM_GPIO(7)) dut (.clock_i(clock_i),
    .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata), .err_i(err), .rx_lock_raw_i(raw),
    .equalizer_filter_step_i(step), .remote_selftest_active_i(remote),
    .local_selftest_pin_i(local_pin), .frame_start_i(fstart), .gpio_output_mode_i(gmode),
    .lock_o(lock), .crc_check_en_o(crc_en), .pulldown_en_o(pd_en),
    .selftest_mismatch_o(mism), .return_bit_flip_o(flip));

  initial
  begin
    forever #25 clock_i = ~clock_i;
  end

  // lock drops and corrupted frames, counted on the clock edge
  always @(posedge clock_i)
  begin
    if (lock_d1 === 1'b1 && lock === 1'b0)
      n_drop++;
    if (flip === 1'b1)
      n_flip++;
    lock_d1 = lock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req <= '0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req <= '0;
    #1 chk(rdata, exp);
  endtask : rchk

  // one error cycle on the link, optionally with a filter step beside it
  task automatic hit(input link_err_t e, input logic s);
    @(posedge clock_i);
    err_req <= e;
    step <= s;
    @(posedge clock_i);
    err_req <= '0;
    step <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : hit

  task automatic wait_lock();
    for (int i = 0; i < 20 && lock !== 1'b1; i++)
      @(posedge clock_i);
    if (lock !== 1'b1)
    begin
      n_fail++;
      $display("wrong value at %0t: lock never came", $time);
      test_done();
    end
  endtask : wait_lock

  // one-shot windows start before the write, others after it settles
  task automatic flips(input logic [7:0] d, input int exp);
    int base;
    #1 base = n_flip;
    wr(OFS_DEBUG_INJECTION_STATUS, d);
    repeat (3) @(posedge clock_i);
    if (!d[0])
      #1 base = n_flip;
    repeat (40) @(posedge clock_i);
    #1 chk(8'(n_flip - base), 8'(exp));
  endtask : flips

  // errors needed for one drop; zero threshold acts as one
  function automatic int thr(input logic [7:0] c);
    if (!c[4])
      return 1;
    return (c[3:0] == 4'h0) ? 1 : int'(c[3:0]);
  endfunction : thr

  initial
  begin
    logic [7:0] ctl, msk, v;
    int exp_d, cnt, n;
    link_err_t e;
    void'($urandom(32'h6631));
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    // reset values; unmapped place reads zero
    rchk(OFS_LINK_ERROR_CONTROL, 8'h33);
    rchk(OFS_ENCODER_CRC_CONTROL, 8'h83);
    rchk(OFS_ERROR_SOURCE_MASK, 8'h00);
    rchk(OFS_RESERVED_BD, 8'h00);
    rchk(OFS_GPIO_PULLDOWN_DISABLE, 8'h00);
    rchk(OFS_DEBUG_INJECTION_STATUS, 8'h00);
    wr(8'h55, 8'hff);
    rchk(8'h55, 8'h00);
    chk({7'h00, crc_en}, 8'h00);
    // software clears the crc control bit; the flag elsewhere is outside
    wr(OFS_ENCODER_CRC_CONTROL, 8'h03);
    @(posedge clock_i);
    #1 chk({7'h00, crc_en}, 8'h01);
    $display("reset and crc test done");
    // pulldowns against random pin modes
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      @(posedge clock_i);
      gmode <= 7'($urandom);
      wr(OFS_GPIO_PULLDOWN_DISABLE, v);
      repeat (2) @(posedge clock_i);
      #1 chk({1'b0, pd_en}, {1'b0, ~gmode & ~v[6:0]});
      rchk(OFS_GPIO_PULLDOWN_DISABLE, {1'b0, v[6:0]});
    end
    $display("pulldown test done");
    // counted errors against threshold, enable and source masks
    for (int r = 0; r < 7; r++)
    begin
      ctl = (r == 0) ? 8'h1f : (r == 1) ? 8'h05 : 8'($urandom) & 8'h3f;
      msk = (r < 2) ? 8'h00 : 8'($urandom) & 8'h07;
      @(posedge clock_i);
      raw <= 1'b0;
      wr(OFS_LINK_ERROR_CONTROL, ctl);
      wr(OFS_ERROR_SOURCE_MASK, msk);
      raw <= 1'b1;
      wait_lock();
      rchk(OFS_LINK_ERROR_CONTROL, ctl);
      rchk(OFS_ERROR_SOURCE_MASK, msk);
      n = (r == 0) ? 17 : 1 + $urandom % 12;
      cnt = 0;
      exp_d = n_drop;
      for (int k = 0; k < n; k++)
      begin
        e = 3'(1 + $urandom % 7);
        hit(e, 1'b0);
        if ((e & ~msk[2:0]) != 3'h0)
          cnt++;
        if (cnt >= thr(ctl))
        begin
          exp_d++;
          cnt = 0;
        end
      end
      chk(8'(n_drop), 8'(exp_d));
    end
    // errors inside the filter wait window
    wr(OFS_ERROR_SOURCE_MASK, 8'h00);
    wr(OFS_LINK_ERROR_CONTROL, 8'h20);
    exp_d = n_drop;
    hit(3'h4, 1'b1);
    chk(8'(n_drop), 8'(exp_d));
    wr(OFS_LINK_ERROR_CONTROL, 8'h00);
    hit(3'h4, 1'b1);
    chk(8'(n_drop), 8'(exp_d + 1));
    $display("lock test done");
    // remote self-test flag against the local pin
    remote <= 1'b1;
    repeat (6) @(posedge clock_i);
    #1 chk({7'h00, mism}, 8'h01);
    rchk(OFS_DEBUG_INJECTION_STATUS, 8'h20);
    local_pin <= 1'b1;
    repeat (6) @(posedge clock_i);
    #1 chk({7'h00, mism}, 8'h00);
    @(posedge clock_i);
    remote <= 1'b0;
    wr(OFS_DEBUG_INJECTION_STATUS, 8'hfc);
    rchk(OFS_DEBUG_INJECTION_STATUS, 8'hdc);
    $display("self-test flag test done");
    // one-shot, rewrite over one, re-arm, then continuous
    flips(8'h00, 0);
    flips(8'h01, 1);
    flips(8'h01, 0);
    flips(8'h00, 0);
    flips(8'h01, 1);
    flips(8'h02, 5);
    flips(8'h00, 0);
    $display("injection test done");
    test_done();
  end
endmodule : tb_link_error_lock_monitor
`default_nettype wire
